// ==== core/gpio_port_defines.svh ====
// Register offsets, field positions, reset values and widths of the six-bit port
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

`define PORT_ADDR_W 16
`define PORT_DATA_W 8
`define PORT_PIN_N 6
`define PORT_PIN_MSB 5
`define PORT_RSV_MSB 7
`define PORT_RSV_LSB 6

`define PORT_LATCH_ADDR 16'h7fd4
`define PORT_INPUT_ADDR 16'h7fd5
`define PORT_DIR_ADDR 16'h7fd6
`define PORT_FUNC_ADDR 16'h7ffd

`define PORT_LATCH_RST 6'h00
`define PORT_DIR_RST 6'h00
`define PORT_FUNC_RST 6'h00
`define PORT_RDATA_RST 8'h00
`define PORT_RSV_READ 2'h0

`endif

// ==== core/gpio_port_pkg.sv ====
// Types shared by the six-bit port
package gpio_port_pkg;

  typedef enum logic [2:0] {
    MODE_OPEN      = 3'b000,
    MODE_PULL_UP   = 3'b001,
    MODE_PUSH_PULL = 3'b010,
    MODE_SLOW      = 3'b011,
    MODE_DRIVE_LOW = 3'b100,
    MODE_INV_IN    = 3'b101
  } pin_mode_e;

  typedef logic [5:0] pin_vec_t;

endpackage : gpio_port_pkg

// ==== core/gpio_port.sv ====
// Six-bit general-purpose port with pull-ups, slow-change drive and inverted input
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

// Summary of operation
// - Six pins, each set to input or output by its own direction bit.
// - The output latch at 7fd4 supplies the level driven on each output pin.
// - The direction register at 7fd6 sets each pin to input or output.
// - The function register at 7ffd picks the output mode of each pin.
// - Each pin has a pull-up that its latch bit turns on while it is an input with function 0.
// - Reading the input address returns the pin levels of bits 5 to 0 in any direction.
// - Function 0 gives open, pull-up, or push-pull drive of the latch value.
// - Function 1 with input direction drives the latch slowly; with output and latch 0 drives low.
// - Function, latch and direction all 1 leave the pin open and read it inverted.
// - Latch, direction and function reset to zero, and bits 7 and 6 always read low.
// - In the halt and hold modes every pin keeps the state it had on entry.
module gpio_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Halt, hold and extended_stop_mode indication
  input wire logic low_power_hold_i,
  // Pins
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe_n_o,
  output logic [5:0] pull_en_o,
  output logic [5:0] slow_o
);

  function automatic gpio_port_pkg::pin_mode_e pin_mode(input logic f, input logic l,
                                                         input logic d);
    gpio_port_pkg::pin_mode_e m;
    m = gpio_port_pkg::MODE_OPEN;
    case ({f, d})
      2'b00: m = l ? gpio_port_pkg::MODE_PULL_UP : gpio_port_pkg::MODE_OPEN;
      2'b01: m = gpio_port_pkg::MODE_PUSH_PULL;
      2'b10: m = gpio_port_pkg::MODE_SLOW;
      2'b11: m = l ? gpio_port_pkg::MODE_INV_IN : gpio_port_pkg::MODE_DRIVE_LOW;
      default: m = gpio_port_pkg::MODE_OPEN;
    endcase
    return m;
  endfunction : pin_mode

  gpio_port_pkg::pin_vec_t latch_r;
  gpio_port_pkg::pin_vec_t dir_r;
  gpio_port_pkg::pin_vec_t func_r;
  gpio_port_pkg::pin_vec_t sync1_r;
  gpio_port_pkg::pin_vec_t sync2_r;
  gpio_port_pkg::pin_vec_t sync3_r;
  gpio_port_pkg::pin_vec_t pin_lvl_r;
  gpio_port_pkg::pin_vec_t inv_mask;
  logic [7:0] rdata_nxt;

  // Registers; bits 7 and 6 are simply not stored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_r <= `PORT_LATCH_RST;
      dir_r <= `PORT_DIR_RST;
      func_r <= `PORT_FUNC_RST;
    end else if (wr_i) begin
      case (addr_i)
        `PORT_LATCH_ADDR: latch_r <= wdata_i[`PORT_PIN_MSB:0];
        `PORT_DIR_ADDR: dir_r <= wdata_i[`PORT_PIN_MSB:0];
        `PORT_FUNC_ADDR: func_r <= wdata_i[`PORT_PIN_MSB:0];
        default: ;
      endcase
    end
  end

  // Three-stage pin sampler; a level is taken once stages two and three agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      sync3_r <= 6'h00;
      pin_lvl_r <= 6'h00;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < `PORT_PIN_N; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_lvl_r[i] <= sync3_r[i];
        end
      end
    end
  end

  assign inv_mask = func_r & latch_r & dir_r;

  always_comb begin
    rdata_nxt = `PORT_RDATA_RST;
    case (addr_i)
      `PORT_LATCH_ADDR: rdata_nxt = {`PORT_RSV_READ, latch_r};
      `PORT_INPUT_ADDR: rdata_nxt = {`PORT_RSV_READ, pin_lvl_r ^ inv_mask};
      `PORT_DIR_ADDR: rdata_nxt = {`PORT_RSV_READ, dir_r};
      `PORT_FUNC_ADDR: rdata_nxt = {`PORT_RSV_READ, func_r};
      default: rdata_nxt = `PORT_RDATA_RST;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `PORT_RDATA_RST;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= `PORT_RDATA_RST;
    end
  end

  // Pin drivers are frozen while a low-power mode holds; software may still write the
  // registers and the new setting appears once the mode ends
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= 6'h00;
      pin_oe_n_o <= 6'h3f;
      pull_en_o <= 6'h00;
      slow_o <= 6'h00;
    end else if (!low_power_hold_i) begin
      for (int i = 0; i < `PORT_PIN_N; i++) begin
        pin_o[i] <= 1'b0;
        pin_oe_n_o[i] <= 1'b1;
        pull_en_o[i] <= 1'b0;
        slow_o[i] <= 1'b0;
        case (pin_mode(func_r[i], latch_r[i], dir_r[i]))
          gpio_port_pkg::MODE_OPEN: ;
          gpio_port_pkg::MODE_PULL_UP: pull_en_o[i] <= 1'b1;
          gpio_port_pkg::MODE_PUSH_PULL: begin
            pin_o[i] <= latch_r[i];
            pin_oe_n_o[i] <= 1'b0;
          end
          gpio_port_pkg::MODE_SLOW: begin
            pin_o[i] <= latch_r[i];
            pin_oe_n_o[i] <= 1'b0;
            slow_o[i] <= 1'b1;
          end
          gpio_port_pkg::MODE_DRIVE_LOW: pin_oe_n_o[i] <= 1'b0;
          gpio_port_pkg::MODE_INV_IN: ;
          default: ;
        endcase
      end
    end
  end

  a_hold_keeps_pins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    low_power_hold_i |=> $stable(pin_o) && $stable(pin_oe_n_o) && $stable(pull_en_o)
      && $stable(slow_o))
    else $error("pins changed during low-power hold");

  a_latch_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_i && addr_i == `PORT_LATCH_ADDR |=> latch_r == $past(wdata_i[5:0]))
    else $error("latch write not stored");

  a_dir_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_i && addr_i == `PORT_DIR_ADDR ##1 rd_i && addr_i == `PORT_DIR_ADDR
      |=> rdata_o == {2'h0, $past(wdata_i[5:0], 2)})
    else $error("direction readback wrong");

  a_func_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_i && addr_i == `PORT_FUNC_ADDR |=> func_r == $past(wdata_i[5:0]))
    else $error("function write not stored");

  a_input_no_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_i && addr_i == `PORT_INPUT_ADDR |=> $stable(latch_r) && $stable(dir_r) && $stable(func_r))
    else $error("write to input address changed a register");

  a_reserved_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rdata_o[7:6] == 2'h0)
    else $error("reserved bits read high");

  a_input_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rd_i && addr_i == `PORT_INPUT_ADDR |=> rdata_o[5:0] == ($past(pin_lvl_r) ^ $past(inv_mask)))
    else $error("input read wrong");

  a_sampler_agree: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pin_lvl_r != $past(pin_lvl_r) |-> ($past(sync2_r) == $past(sync3_r))
      || ((pin_lvl_r ^ $past(pin_lvl_r)) & ($past(sync2_r) ^ $past(sync3_r))) == 6'h00)
    else $error("pin level taken before stages agreed");

  for (genvar g = 0; g < `PORT_PIN_N; g++) begin : g_chk
    a_push_pull: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !low_power_hold_i && !func_r[g] && dir_r[g]
        |=> !pin_oe_n_o[g] && pin_o[g] == $past(latch_r[g]) && !pull_en_o[g])
      else $error("push-pull drive wrong");
    a_pull_up: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !low_power_hold_i && !func_r[g] && !dir_r[g]
        |=> pin_oe_n_o[g] && pull_en_o[g] == $past(latch_r[g]))
      else $error("pull-up control wrong");
    a_slow_change: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !low_power_hold_i && func_r[g] && !dir_r[g]
        |=> slow_o[g] && !pin_oe_n_o[g] && pin_o[g] == $past(latch_r[g]))
      else $error("slow-change drive wrong");
    a_drive_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !low_power_hold_i && func_r[g] && dir_r[g] && !latch_r[g]
        |=> !pin_oe_n_o[g] && !pin_o[g] && !slow_o[g])
      else $error("drive-low mode wrong");
    a_inverted_open: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !low_power_hold_i && func_r[g] && dir_r[g] && latch_r[g]
        |=> pin_oe_n_o[g] && !pull_en_o[g])
      else $error("inverted input pin not open");
  end

endmodule : gpio_port

// ==== tb/pin_board.sv ====
// Board model of the six port pins: port drive, board drive, pull-ups, floating lines
`timescale 1ns/1ps
module pin_board (
  // Clock
  input wire logic clk_i,
  // Port side
  input wire logic [5:0] pin_o_i,
  input wire logic [5:0] oe_n_i,
  input wire logic [5:0] pull_en_i,
  // Board drive
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] ext_val_i,
  output logic [5:0] level_o
);
  // A floating line toggles, so a settled guess never passes for a level
  logic [5:0] float_r = 6'h15;
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!oe_n_i[i]) level_o[i] = pin_o_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pull_en_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_r[i];
    end
  end
endmodule : pin_board

// ==== tb/tb_top.sv ====
// Self-checking bench for the six-bit port
`timescale 1ns/1ps
`include "gpio_port_defines.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold = 1'b0;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_val = 6'h00;
  logic [7:0] rdata;
  logic [7:0] rv;
  gpio_port_pkg::pin_vec_t lvl, pin_o, oe_n, pull, slow;
  logic [23:0] pins;
  int err_count = 0;
  int n_checks = 0;
  logic [3:0] mtab [0:7] = '{4'h8, 4'h0, 4'ha, 4'h4, 4'h1, 4'h0, 4'h5, 4'h8};
  assign pins = {oe_n, pin_o, pull, slow};
  always #50 clk_i = ~clk_i;
  gpio_port DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .low_power_hold_i(hold), .pin_i(lvl),
    .pin_o(pin_o), .pin_oe_n_o(oe_n), .pull_en_o(pull), .slow_o(slow));
  pin_board board (.clk_i(clk_i), .pin_o_i(pin_o), .oe_n_i(oe_n), .pull_en_i(pull),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so it is taken there
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // Write then read with no gap between the strobes
  task automatic wr_rd_reg(input logic [15:0] a, input logic [7:0] d, output logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : wr_rd_reg
  task automatic t_basic();
    logic [15:0] rw [0:2] = '{`PORT_LATCH_ADDR, `PORT_DIR_ADDR, `PORT_FUNC_ADDR};
    cyc(1);
    chk("reset pins", pins, 24'hfc0000);
    @(posedge clk_i);
    ext_en <= 6'h3f;
    foreach (rw[i]) begin
      rd_reg(rw[i], rv);
      chk("reset reg", rv, 8'h00);
      wr_reg(rw[i], 8'hff);
      rd_reg(rw[i], rv);
      chk("rw reg", rv, 8'h3f);
      wr_reg(rw[i], 8'h00);
    end
    wr_rd_reg(`PORT_DIR_ADDR, 8'hd5, rv);
    chk("dir back to back", rv, 8'h15);
    wr_reg(`PORT_DIR_ADDR, 8'h00);
    wr_reg(`PORT_INPUT_ADDR, 8'hff);
    cyc(8);
    rd_reg(`PORT_INPUT_ADDR, rv);
    chk("input read", rv, 8'h00);
    rd_reg(16'h7fd7, rv);
    chk("unmapped read", rv, 8'h00);
    $display("test basic done");
  endtask : t_basic
  task automatic t_modes();
    logic [3:0] t;
    logic [5:0] e;
    logic [23:0] x;
    @(posedge clk_i);
    ext_val <= 6'h2d;
    for (int m = 0; m < 8; m++) begin
      t = mtab[m];
      wr_reg(`PORT_FUNC_ADDR, {2'b00, {6{m[2]}}});
      wr_reg(`PORT_LATCH_ADDR, {2'b00, {6{m[1]}}});
      wr_reg(`PORT_DIR_ADDR, {2'b00, {6{m[0]}}});
      cyc(8);
      x = {{6{t[3]}}, {6{t[2]}}, {6{t[1]}}, {6{t[0]}}};
      chk("pin mode", pins, x);
      e = (m == 7) ? 6'h12 : (t[3] ? 6'h2d : {6{t[2]}});
      rd_reg(`PORT_INPUT_ADDR, rv);
      chk("pin read", rv, {2'b00, e});
    end
    @(posedge clk_i);
    ext_en <= 6'h00;
    wr_reg(`PORT_FUNC_ADDR, 8'h00);
    wr_reg(`PORT_DIR_ADDR, 8'h00);
    cyc(8);
    rd_reg(`PORT_INPUT_ADDR, rv);
    chk("pull read", rv, 8'h3f);
    $display("test modes done");
  endtask : t_modes
  task automatic t_hold();
    wr_reg(`PORT_DIR_ADDR, 8'h2a);
    cyc(2);
    chk("mixed pins", pins, 24'h56a540);
    @(posedge clk_i);
    hold <= 1'b1;
    wr_reg(`PORT_DIR_ADDR, 8'h00);
    cyc(3);
    chk("held pins", pins, 24'h56a540);
    @(posedge clk_i);
    hold <= 1'b0;
    cyc(3);
    chk("released pins", pins, 24'hfc0fc0);
    // Reset again in mid-run: pins open and registers cleared
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    cyc(2);
    chk("mid reset pins", pins, 24'hfc0000);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_reg(`PORT_LATCH_ADDR, rv);
    chk("mid reset latch", rv, 8'h00);
    $display("test hold done");
  endtask : t_hold
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // A stuck run is cut short here and counted as a mismatch
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_basic();
    t_modes();
    t_hold();
    stop_test();
  end
endmodule : tb_top
